// ---- daq_board_control_port_regs.sv ----
/*
 * Host-visible control registers of the acquisition board: burst control,
 * gain codes, two DAC codes, FIFO and jumper status, sticky flags and the
 * serial calibration-memory port.
 * Assumes host I/O strobes are single-cycle pulses on clk_sys, FIFO flags
 * come from logic on clk_sys, and jumpers and the memory output are pins.
 */
module daq_board_control_port_regs
	import daq_ctl_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	input  wire logic [ADDR_W-1:0]     bus_addr,
	input  wire logic [DATA_W-1:0]     bus_wdata,
	input  wire logic                  bus_word,
	input  wire logic                  bus_wr,
	input  wire logic                  bus_rd,
	output logic      [DATA_W-1:0]     bus_rdata,
	output logic                       bus_rvalid,
	input  wire logic                  fifo_empty,
	input  wire logic                  fifo_full,
	input  wire logic                  fifo_half_flag,
	input  wire logic [3:0]            scan_start_channel,
	input  wire logic [3:0]            scan_channel,
	input  wire logic                  dac_simultaneous,
	input  wire logic [JUMPER_W-1:0]   jumper_pins,
	input  wire logic                  rom_dout_pin,
	output logic                       conv_start,
	output logic                       mux_hold,
	output logic      [3:0]            adc_channel,
	output logic      [GAIN_CODE_W-1:0] amp_gain,
	output logic      [DAC_CODE_W-1:0] dac_first_code,
	output logic      [DAC_CODE_W-1:0] dac_second_code,
	output logic                       half_irq,
	output logic                       rom_sel,
	output logic                       rom_sclk,
	output logic                       rom_din
);

	// Gain code of one channel out of the two packed code words.
	function automatic logic [1:0] gain_of(
		input logic [15:0] low_codes,
		input logic [15:0] high_codes,
		input logic [3:0]  chan
	);
		logic [15:0] word;
		word = chan[3] ? high_codes : low_codes;
		return word[{chan[2:0], 1'b0} +: 2];
	endfunction : gain_of

	// Byte or word merge into a 16-bit register; odd offsets carry the
	// high byte on the low data lane, as a byte cycle does on this bus.
	function automatic logic [15:0] merge_word(
		input logic [15:0] old_val,
		input logic [15:0] wdata,
		input logic        word,
		input logic        odd
	);
		logic [15:0] res;
		res = old_val;
		if (word) begin
			res = wdata;
		end else if (odd) begin
			res[15:8] = wdata[7:0];
		end else begin
			res[7:0] = wdata[7:0];
		end
		return res;
	endfunction : merge_word

	typedef struct packed {
		logic [JUMPER_W-1:0]   jmp_meta;
		logic [JUMPER_W-1:0]   jmp;
		logic                  rom_meta;
		logic                  rom_in;
		logic                  burst_on;
		logic [4:0]            conv_cnt;
		logic                  conv_start;
		logic [15:0]           gain_lo;
		logic [15:0]           gain_hi;
		logic [11:0]           dac_first_hold;
		logic [11:0]           dac_second_hold;
		logic [11:0]           dac_first_out;
		logic [11:0]           dac_second_out;
		logic                  irq_en;
		logic                  irq;
		logic                  stk_full;
		logic                  stk_empty_rd;
		logic [3:0]            chan;
		logic [1:0]            gain;
		logic [15:0]           rdata;
		logic                  rvalid;
	} state_s;

	state_s s_q;
	state_s s_d;

	// The synchroniser lives outside the state struct: it alone is reset by
	// the raw pin, and one variable may be written by one process only.
	logic [1:0] rst_sync_q;
	logic rst_sync_n;
	logic rom_busy;
	logic wr_rom;

	// Reset is released through two flops; the rest of the design uses it.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync_q[1];

	assign wr_rom = bus_wr && (bus_addr == OFF_ROM_PORT);

	always_comb begin
		logic [3:0]  next_chan;
		logic        wr_dac_first;
		logic        wr_dac_second;
		logic [11:0] code;
		next_chan     = 4'h0;
		wr_dac_first  = 1'b0;
		wr_dac_second = 1'b0;
		code          = 12'h000;
		s_d           = s_q;

		// Pins pass two flops before anything reads them.
		s_d.jmp_meta = jumper_pins;
		s_d.jmp      = s_q.jmp_meta;
		s_d.rom_meta = rom_dout_pin;
		s_d.rom_in   = s_q.rom_meta;

		s_d.conv_start = 1'b0;
		s_d.rvalid     = 1'b0;

		if (bus_wr) begin
			unique case (bus_addr)
				OFF_BURST: begin
					if (bus_wdata[7:0] == BURST_START) begin
						s_d.burst_on = 1'b1;
						s_d.conv_cnt = 5'h00;
					end else if (bus_wdata[7:0] == BURST_STOP) begin
						s_d.burst_on = 1'b0;
					end
				end
				OFF_GAIN_LO, OFF_GAIN_LO_HI: begin
					s_d.gain_lo = merge_word(s_q.gain_lo, bus_wdata, bus_word,
						bus_addr[0]);
				end
				OFF_GAIN_HI, OFF_GAIN_CLEAR: begin
					s_d.gain_hi = merge_word(s_q.gain_hi, bus_wdata, bus_word,
						bus_addr[0]);
				end
				OFF_DAC_FIRST: begin
					wr_dac_first = bus_word;
				end
				OFF_DAC_SECOND: begin
					wr_dac_second = bus_word;
				end
				OFF_IRQ_ENABLE: begin
					if (bus_wdata[7:0] == IRQ_ON_VALUE) begin
						s_d.irq_en = 1'b1;
					end else if (bus_wdata[7:0] == IRQ_OFF_VALUE) begin
						s_d.irq_en = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// The code sits in the low twelve bits; the host keeps the rest zero.
		code = bus_wdata[DAC_CODE_W-1:0];
		if (wr_dac_first) begin
			if (!dac_simultaneous) begin
				s_d.dac_first_hold = code;
				s_d.dac_first_out  = code;
			end else if (bus_wdata == DAC_LOAD_BOTH) begin
				s_d.dac_first_out  = s_q.dac_first_hold;
				s_d.dac_second_out = s_q.dac_second_hold;
			end else begin
				s_d.dac_first_hold = code;
			end
		end
		if (wr_dac_second) begin
			s_d.dac_second_hold = code;
			if (!dac_simultaneous) begin
				s_d.dac_second_out = code;
			end
		end

		// Burst pacing: one start per period, paused while the FIFO is full.
		// The counter holds at zero during a pause so the first start after
		// the host drains a sample is not delayed by a whole period.
		if (s_q.burst_on) begin
			if (s_q.conv_cnt != 5'h00) begin
				s_d.conv_cnt = s_q.conv_cnt - 5'h01;
			end else if (!fifo_full) begin
				s_d.conv_start = 1'b1;
				s_d.conv_cnt   = CONV_RELOAD;
			end
		end

		// Burst holds the mux on the scan start channel.
		next_chan = s_q.burst_on ? scan_start_channel : scan_channel;
		s_d.chan  = next_chan;
		s_d.gain  = gain_of(s_q.gain_lo, s_q.gain_hi, next_chan);

		s_d.irq = s_q.irq_en && fifo_half_flag;

		// Sticky flags: a new event in the clearing read's cycle survives.
		s_d.stk_full     = s_q.stk_full;
		s_d.stk_empty_rd = s_q.stk_empty_rd;
		if (bus_rd && (bus_addr == OFF_STICKY)) begin
			s_d.stk_full     = 1'b0;
			s_d.stk_empty_rd = 1'b0;
		end
		if (fifo_full) begin
			s_d.stk_full = 1'b1;
		end
		if (bus_rd && (bus_addr == OFF_FIFO_DATA) && fifo_empty) begin
			s_d.stk_empty_rd = 1'b1;
		end

		if (bus_rd) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = 16'h0000;
			unique case (bus_addr)
				OFF_GAIN_CLEAR: begin
					s_d.gain_lo = GAIN_RESET;
					s_d.gain_hi = GAIN_RESET;
				end
				OFF_DAC_FIRST: begin
					s_d.rdata[ST_EMPTY_BIT] = fifo_empty;
					s_d.rdata[ST_FULL_BIT]  = fifo_full;
					s_d.rdata[ST_HALF_BIT]  = fifo_half_flag;
					s_d.rdata[JUMPER_W-1:0] = s_q.jmp;
				end
				OFF_STICKY: begin
					s_d.rdata[STK_FULL_BIT]  = s_q.stk_full || fifo_full;
					s_d.rdata[STK_EMPTY_BIT] = s_q.stk_empty_rd;
				end
				OFF_ROM_PORT: begin
					s_d.rdata[ROM_DATA_BIT] = s_q.rom_in;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_q.jmp_meta        <= '0;
			s_q.jmp             <= '0;
			s_q.rom_meta        <= 1'b0;
			s_q.rom_in          <= 1'b0;
			s_q.burst_on        <= 1'b0;
			s_q.conv_cnt        <= 5'h00;
			s_q.conv_start      <= 1'b0;
			s_q.gain_lo         <= GAIN_RESET;
			s_q.gain_hi         <= GAIN_RESET;
			s_q.dac_first_hold  <= DAC_RESET;
			s_q.dac_second_hold <= DAC_RESET;
			s_q.dac_first_out   <= DAC_RESET;
			s_q.dac_second_out  <= DAC_RESET;
			s_q.irq_en          <= 1'b0;
			s_q.irq             <= 1'b0;
			s_q.stk_full        <= 1'b0;
			s_q.stk_empty_rd    <= 1'b0;
			s_q.chan            <= 4'h0;
			s_q.gain            <= 2'h0;
			s_q.rdata           <= 16'h0000;
			s_q.rvalid          <= 1'b0;
		end else if (clk_en) begin
			s_q.jmp_meta        <= s_d.jmp_meta;
			s_q.jmp             <= s_d.jmp;
			s_q.rom_meta        <= s_d.rom_meta;
			s_q.rom_in          <= s_d.rom_in;
			s_q.burst_on        <= s_d.burst_on;
			s_q.conv_cnt        <= s_d.conv_cnt;
			s_q.conv_start      <= s_d.conv_start;
			s_q.gain_lo         <= s_d.gain_lo;
			s_q.gain_hi         <= s_d.gain_hi;
			s_q.dac_first_hold  <= s_d.dac_first_hold;
			s_q.dac_second_hold <= s_d.dac_second_hold;
			s_q.dac_first_out   <= s_d.dac_first_out;
			s_q.dac_second_out  <= s_d.dac_second_out;
			s_q.irq_en          <= s_d.irq_en;
			s_q.irq             <= s_d.irq;
			s_q.stk_full        <= s_d.stk_full;
			s_q.stk_empty_rd    <= s_d.stk_empty_rd;
			s_q.chan            <= s_d.chan;
			s_q.gain            <= s_d.gain;
			s_q.rdata           <= s_d.rdata;
			s_q.rvalid          <= s_d.rvalid;
		end
	end

	// Host must space port writes by a full pulse and observe the memory's
	// own programming time; the port neither enforces nor reports it.
	serial_rom_port u_rom_port (
		.clk_sys  (clk_sys),
		.rst_n    (rst_sync_n),
		.clk_en   (clk_en),
		.wr_stb   (wr_rom),
		.wr_byte  (bus_wdata[7:0]),
		.rom_sel  (rom_sel),
		.rom_sclk (rom_sclk),
		.rom_din  (rom_din),
		.rom_busy (rom_busy)
	);

	assign bus_rdata       = s_q.rdata;
	assign bus_rvalid      = s_q.rvalid;
	assign conv_start      = s_q.conv_start;
	assign mux_hold        = s_q.burst_on;
	assign adc_channel     = s_q.chan;
	assign amp_gain        = s_q.gain;
	assign dac_first_code  = s_q.dac_first_out;
	assign dac_second_code = s_q.dac_second_out;
	assign half_irq        = s_q.irq;

endmodule : daq_board_control_port_regs

// ---- daq_ctl_pkg.sv ----
/*
 * Constants shared by the acquisition-board control registers: offsets,
 * field positions, reset values and cycle counts.
 * Assumes a 10 MHz system clock and host I/O strobes already on that clock.
 */
package daq_ctl_pkg;

	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 16;

	localparam logic [4:0] OFF_FIFO_DATA   = 5'h00;
	localparam logic [4:0] OFF_BURST       = 5'h03;
	localparam logic [4:0] OFF_GAIN_LO     = 5'h04;
	localparam logic [4:0] OFF_GAIN_LO_HI  = 5'h05;
	localparam logic [4:0] OFF_GAIN_HI     = 5'h06;
	localparam logic [4:0] OFF_GAIN_CLEAR  = 5'h07;
	localparam logic [4:0] OFF_DAC_FIRST   = 5'h08;
	localparam logic [4:0] OFF_STICKY      = 5'h09;
	localparam logic [4:0] OFF_ROM_PORT    = 5'h0A;
	localparam logic [4:0] OFF_IRQ_ENABLE  = 5'h0C;
	localparam logic [4:0] OFF_DAC_SECOND  = 5'h0E;

	localparam logic [7:0] BURST_START     = 8'h01;
	localparam logic [7:0] BURST_STOP      = 8'h00;
	localparam logic [7:0] IRQ_ON_VALUE    = 8'h10;
	localparam logic [7:0] IRQ_OFF_VALUE   = 8'h00;
	localparam logic [15:0] DAC_LOAD_BOTH  = 16'h8000;

	localparam int unsigned ST_EMPTY_BIT   = 7;
	localparam int unsigned ST_FULL_BIT    = 6;
	localparam int unsigned ST_HALF_BIT    = 5;
	localparam int unsigned STK_FULL_BIT   = 0;
	localparam int unsigned STK_EMPTY_BIT  = 1;
	localparam int unsigned ROM_DATA_BIT   = 7;
	localparam int unsigned ROM_SEL_BIT    = 0;
	localparam int unsigned DAC_CODE_W     = 12;
	localparam int unsigned GAIN_CODE_W    = 2;
	localparam int unsigned JUMPER_W       = 5;

	localparam logic [15:0] GAIN_RESET     = 16'h0000;
	localparam logic [11:0] DAC_RESET      = 12'h000;

	localparam int unsigned CLK_PERIOD_NS  = 100;
	localparam int unsigned CONV_PERIOD_NS = 2000;
	localparam int unsigned CONV_CYCLES    = CONV_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned SCLK_PHASE_NS  = 500;
	localparam int unsigned SCLK_CYCLES    =
		(SCLK_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] CONV_RELOAD     = 5'(CONV_CYCLES - 1);
	localparam logic [3:0] SCLK_RELOAD     = 4'(SCLK_CYCLES - 1);

endpackage : daq_ctl_pkg

// ---- serial_rom_port.sv ----
/*
 * Bit-serial port to the calibration memory: each host write taken while idle sets data and
 * select, then emits one serial clock pulse.
 * Assumes one-cycle write strobes on clk_sys and a synchronised rst_n.
 */
module serial_rom_port
	import daq_ctl_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       wr_stb,
	input  wire logic [7:0] wr_byte,
	output logic            rom_sel,
	output logic            rom_sclk,
	output logic            rom_din,
	output logic            rom_busy
);

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_SETUP,
		PH_HIGH
	} phase_e;

	typedef struct packed {
		phase_e     phase;
		logic [3:0] cnt;
		logic       sel;
		logic       sclk;
		logic       din;
	} state_s;

	state_s s_q;
	state_s s_d;

	// A write that lands mid-pulse is dropped; the host bus is far slower
	// than one pulse, so only a runaway driver would see this.
	always_comb begin
		s_d = s_q;
		unique case (s_q.phase)
			PH_IDLE: begin
				if (wr_stb) begin
					s_d.din   = wr_byte[ROM_DATA_BIT];
					s_d.sel   = wr_byte[ROM_SEL_BIT];
					s_d.cnt   = SCLK_RELOAD;
					s_d.phase = PH_SETUP;
				end
			end
			PH_SETUP: begin
				if (s_q.cnt == 4'h0) begin
					s_d.sclk  = 1'b1;
					s_d.cnt   = SCLK_RELOAD;
					s_d.phase = PH_HIGH;
				end else begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
			end
			PH_HIGH: begin
				if (s_q.cnt == 4'h0) begin
					s_d.sclk  = 1'b0;
					s_d.phase = PH_IDLE;
				end else begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{phase: PH_IDLE, cnt: 4'h0, sel: 1'b0, sclk: 1'b0, din: 1'b0};
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign rom_sel  = s_q.sel;
	assign rom_sclk = s_q.sclk;
	assign rom_din  = s_q.din;
	assign rom_busy = (s_q.phase != PH_IDLE);

endmodule : serial_rom_port

// ---- daq_regs_props.sv ----
/* Port-level assertions for the acquisition-board control registers.
   Assumes the single clk_sys domain and a bind onto the block's top module. */
module daq_regs_props
	import daq_ctl_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   rst_n,
	input wire logic                   clk_en,
	input wire logic [ADDR_W-1:0]      bus_addr,
	input wire logic [DATA_W-1:0]      bus_wdata,
	input wire logic                   bus_word,
	input wire logic                   bus_wr,
	input wire logic                   bus_rd,
	input wire logic [DATA_W-1:0]      bus_rdata,
	input wire logic                   bus_rvalid,
	input wire logic                   fifo_empty,
	input wire logic                   fifo_full,
	input wire logic                   fifo_half_flag,
	input wire logic [3:0]             scan_start_channel,
	input wire logic                   dac_simultaneous,
	input wire logic                   conv_start,
	input wire logic                   mux_hold,
	input wire logic [3:0]             adc_channel,
	input wire logic [GAIN_CODE_W-1:0] amp_gain,
	input wire logic [DAC_CODE_W-1:0]  dac_first_code,
	input wire logic [DAC_CODE_W-1:0]  dac_second_code,
	input wire logic                   half_irq,
	input wire logic                   rom_sel,
	input wire logic                   rom_sclk,
	input wire logic                   rom_din
);
	logic [4:0] gap_q;
	logic       ok_q;
	logic [3:0] wgap_q;
	wire        port_wr = clk_en && bus_wr && bus_addr == OFF_ROM_PORT;
	wire        dac_wr = clk_en && bus_wr && bus_word;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// Gap counters stand in for repetitions far longer than the tools unroll cheaply.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= 5'h00;
			ok_q <= 1'b0;
			wgap_q <= 4'hF;
		end else begin
			gap_q <= conv_start ? 5'h00 : gap_q + {4'h0, gap_q != 5'h1F};
			ok_q <= conv_start ? !fifo_full : ok_q && mux_hold && !fifo_full && clk_en;
			wgap_q <= port_wr ? 4'h0 : wgap_q + {3'h0, wgap_q != 4'hF};
		end
	end

	sequence burst_cmd(logic [7:0] v);
		clk_en && bus_wr && bus_addr == OFF_BURST && bus_wdata[7:0] == v;
	endsequence
	sequence irq_on;
		clk_en && bus_wr && bus_addr == OFF_IRQ_ENABLE && bus_wdata[7:0] == IRQ_ON_VALUE
			##1 fifo_half_flag[*3];
	endsequence
	sequence sclk_pulse;
		(!rom_sclk)[*5] ##1 rom_sclk[*5] ##1 !rom_sclk;
	endsequence

	burst_on_a: assert property (burst_cmd(BURST_START) |=> mux_hold)
		else $error("burst start did not raise mux_hold");
	burst_off_a: assert property (burst_cmd(BURST_STOP) |=> !mux_hold ##1 (!conv_start)[*8])
		else $error("burst stop left conversions running");
	conv_rate_a: assert property (conv_start && ok_q |-> gap_q == 5'(CONV_CYCLES - 1))
		else $error("conversion period wrong");
	conv_mux_a: assert property (conv_start |-> mux_hold ##1 (!conv_start)[*8])
		else $error("conversion outside burst or too soon");
	full_pause_a: assert property (fifo_full && $past(fifo_full) |-> !conv_start)
		else $error("conversion while fifo full");
	burst_chan_a: assert property (mux_hold && $past(mux_hold) |-> adc_channel == $past(scan_start_channel))
		else $error("burst channel is not the scan start");
	gain_clear_a: assert property (bus_rd && clk_en && bus_addr == OFF_GAIN_CLEAR ##1 !bus_wr |-> ##[0:2] amp_gain == '0)
		else $error("gain not cleared by read");
	dac_auto_a: assert property (!dac_simultaneous && dac_wr && bus_addr == OFF_DAC_FIRST |=> dac_first_code == $past(bus_wdata[11:0]))
		else $error("automatic dac did not update");
	dac_hold_a: assert property (dac_simultaneous && dac_wr && bus_addr == OFF_DAC_SECOND |=> $stable(dac_second_code))
		else $error("simultaneous dac updated early");
	status_bits_a: assert property (clk_en && bus_rd && bus_addr == OFF_DAC_FIRST |=> bus_rvalid && bus_rdata[7:5] == $past({fifo_empty, fifo_full, fifo_half_flag}))
		else $error("status flags wrong");
	irq_on_a: assert property (irq_on |-> half_irq)
		else $error("half full interrupt missing");
	rom_bits_a: assert property (port_wr && wgap_q >= 4'hA |=> rom_din == $past(bus_wdata[7]) && rom_sel == $past(bus_wdata[0]))
		else $error("serial data or select wrong");
	rom_clock_a: assert property (port_wr && wgap_q >= 4'hA |=> sclk_pulse)
		else $error("serial clock pulse wrong");
endmodule : daq_regs_props

bind daq_board_control_port_regs daq_regs_props props_i (
	.clk_sys, .rst_n, .clk_en, .bus_addr, .bus_wdata, .bus_word, .bus_wr, .bus_rd,
	.bus_rdata, .bus_rvalid, .fifo_empty, .fifo_full, .fifo_half_flag, .scan_start_channel,
	.dac_simultaneous, .conv_start, .mux_hold, .adc_channel, .amp_gain, .dac_first_code,
	.dac_second_code, .half_irq, .rom_sel, .rom_sclk, .rom_din
);

// ---- serial_mem_model.sv ----
/* Behavioural model of the serial calibration memory on the port pins.
   Assumes select, clock and data come straight from the block's outputs. */
module serial_mem_model (
	input  wire logic rom_sel,
	input  wire logic rom_sclk,
	input  wire logic rom_din,
	output logic      rom_dout
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:63];
	logic [24:0] sh = '0;
	logic [15:0] out_q = '0;
	int          cnt = 0;
	logic        wen = 1'b0;

	initial begin
		rom_dout = 1'b1;
		foreach (mem[i])
			mem[i] = 16'h0000;
	end
	always @(posedge rom_sclk) begin
		if (rom_sel) begin
			sh = {sh[23:0], rom_din};
			cnt = cnt + 1;
			out_q = {out_q[14:0], 1'b0};
			if (cnt == 9 && sh[8:6] == 3'b110)
				out_q = mem[sh[5:0]];
			rom_dout = out_q[15];
		end
	end
	// A deselect ends the command; the released line no longer shows the old bit.
	always @(negedge rom_sel) begin
		if (cnt == 9 && sh[8:4] == 5'b10011)
			wen = 1'b1;
		if (cnt == 9 && sh[8:4] == 5'b10000)
			wen = 1'b0;
		if (cnt == 25 && sh[24:22] == 3'b101 && wen)
			mem[sh[21:16]] = sh[15:0];
		cnt = 0;
		rom_dout = !rom_dout;
	end
endmodule : serial_mem_model

// ---- tb_daq_board_control_port_regs.sv ----
/* Self-checking bench for the control-register block and its serial memory.
   Assumes the package, design and model files are compiled before it. */
module tb_daq_board_control_port_regs
	import daq_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [4:0]  a;
		logic [15:0] d;
		logic        w;
		logic [3:0]  ch;
		logic [1:0]  g;
		logic [11:0] d0;
		logic [11:0] d1;
	} row_s;
	logic        clk_sys, rst_n, bus_word, bus_wr, bus_rd, bus_rvalid, fifo_empty, fifo_full;
	logic        fifo_half_flag, dac_simultaneous, rom_dout_pin, conv_start, mux_hold;
	logic        half_irq, rom_sel, rom_sclk, rom_din;
	logic [4:0]  bus_addr, jumper_pins;
	logic [15:0] bus_wdata, bus_rdata, rd_val;
	logic [3:0]  scan_start_channel, scan_channel, adc_channel;
	logic [1:0]  amp_gain;
	logic [11:0] dac_first_code, dac_second_code;
	int          failures = 0, checked = 0, cyc = 0, n;
	row_s        rows [8] = '{
		'{5'h04, 16'hE4E4, 1'b1, 4'h3, 2'h3, 12'h000, 12'h000},
		'{5'h05, 16'h0040, 1'b0, 4'h7, 2'h1, 12'h000, 12'h000},
		'{5'h06, 16'h1B00, 1'b1, 4'hC, 2'h3, 12'h000, 12'h000},
		'{5'h06, 16'h0002, 1'b0, 4'h8, 2'h2, 12'h000, 12'h000},
		'{5'h08, 16'h0ABC, 1'b1, 4'h8, 2'h2, 12'hABC, 12'h000},
		'{5'h0E, 16'h0FFF, 1'b1, 4'h1, 2'h1, 12'hABC, 12'hFFF},
		'{5'h08, 16'h0055, 1'b0, 4'h1, 2'h1, 12'hABC, 12'hFFF},
		'{5'h08, 16'h0000, 1'b1, 4'h2, 2'h2, 12'h000, 12'hFFF}};

	daq_board_control_port_regs dut (
		.clk_sys, .rst_n, .clk_en(1'b1), .bus_addr, .bus_wdata, .bus_word, .bus_wr, .bus_rd,
		.bus_rdata, .bus_rvalid, .fifo_empty, .fifo_full, .fifo_half_flag, .scan_start_channel,
		.scan_channel, .dac_simultaneous, .jumper_pins, .rom_dout_pin, .conv_start, .mux_hold,
		.adc_channel, .amp_gain, .dac_first_code, .dac_second_code, .half_irq, .rom_sel,
		.rom_sclk, .rom_din);
	serial_mem_model mem_model (.rom_sel, .rom_sclk, .rom_din, .rom_dout(rom_dout_pin));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = !clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures = failures + 1;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic w);
		@(negedge clk_sys);
		bus_addr = a;
		bus_wdata = d;
		bus_word = w;
		bus_wr = 1'b1;
		@(negedge clk_sys);
		bus_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic w);
		@(negedge clk_sys);
		bus_addr = a;
		bus_word = w;
		bus_rd = 1'b1;
		@(negedge clk_sys);
		bus_rd = 1'b0;
		@(negedge clk_sys);
		rd_val = bus_rdata;
	endtask : rd
	task automatic count_conv(input int len);
		n = 0;
		repeat (len) begin
			@(negedge clk_sys);
			n += int'(conv_start);
		end
	endtask : count_conv
	// Port writes are spaced past the serial pulse, or the block drops them.
	// The model has no programming time, so the bench skips the wait.
	task automatic pw(input logic [7:0] b);
		wr(OFF_ROM_PORT, {8'h00, b}, 1'b0);
		repeat (12) @(negedge clk_sys);
	endtask : pw
	task automatic cmd9(input logic [8:0] v);
		for (int i = 8; i >= 0; i--)
			pw(v[i] ? 8'h81 : 8'h01);
	endtask : cmd9
	task automatic dat16(input logic [15:0] v);
		for (int i = 15; i >= 0; i--)
			pw(v[i] ? 8'h81 : 8'h01);
	endtask : dat16

	initial begin
		{bus_wr, bus_rd, bus_word, fifo_empty, fifo_full, fifo_half_flag, dac_simultaneous} = '0;
		{bus_addr, bus_wdata, jumper_pins, scan_start_channel, scan_channel} = '0;
		rst_n = 1'b0;
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk("idle", 16'h0000, {dac_first_code, mux_hold, half_irq, rom_sel, conv_start});
		foreach (rows[i]) begin
			scan_channel = rows[i].ch;
			wr(rows[i].a, rows[i].d, rows[i].w);
			repeat (4) @(negedge clk_sys);
			chk("gain", {14'h0, rows[i].g}, {14'h0, amp_gain});
			chk("dac0", {4'h0, rows[i].d0}, {4'h0, dac_first_code});
			chk("dac1", {4'h0, rows[i].d1}, {4'h0, dac_second_code});
		end
		scan_channel = 4'hC;
		rd(OFF_GAIN_CLEAR, 1'b0);
		chk("clear_read", 16'h0000, rd_val);
		repeat (3) @(negedge clk_sys);
		chk("gain_clr", 16'h0000, {14'h0, amp_gain});
		dac_simultaneous = 1'b1;
		wr(OFF_DAC_FIRST, 16'h0123, 1'b1);
		wr(OFF_DAC_SECOND, 16'h0456, 1'b1);
		repeat (3) @(negedge clk_sys);
		chk("hold", 16'h0FFF, {4'h0, dac_first_code | dac_second_code});
		wr(OFF_DAC_FIRST, DAC_LOAD_BOTH, 1'b1);
		repeat (3) @(negedge clk_sys);
		chk("both", 16'h1456, {dac_first_code[11:8], dac_second_code});
		dac_simultaneous = 1'b0;
		fifo_empty = 1'b1;
		fifo_half_flag = 1'b1;
		jumper_pins = 5'b10110;
		repeat (4) @(negedge clk_sys);
		rd(OFF_DAC_FIRST, 1'b0);
		chk("status", 16'h00B6, rd_val);
		wr(OFF_IRQ_ENABLE, 16'h0010, 1'b0);
		repeat (3) @(negedge clk_sys);
		chk("irq_on", 16'h0001, {15'h0, half_irq});
		wr(OFF_IRQ_ENABLE, 16'h0000, 1'b0);
		repeat (3) @(negedge clk_sys);
		chk("irq_off", 16'h0000, {15'h0, half_irq});
		rd(OFF_FIFO_DATA, 1'b1);
		fifo_full = 1'b1;
		@(negedge clk_sys);
		fifo_full = 1'b0;
		rd(OFF_STICKY, 1'b0);
		chk("sticky", 16'h0003, {14'h0, rd_val[1:0]});
		rd(OFF_STICKY, 1'b0);
		chk("sticky_clr", 16'h0000, {14'h0, rd_val[1:0]});
		rd(5'h0F, 1'b1);
		chk("unmapped", 16'h0000, rd_val);
		{fifo_empty, fifo_half_flag} = 2'b00;
		scan_start_channel = 4'h5;
		wr(OFF_BURST, 16'h0001, 1'b0);
		repeat (2) @(negedge clk_sys);
		chk("burst", 16'h0015, {11'h0, mux_hold, adc_channel});
		count_conv(200);
		chk("convs", 16'd10, 16'(n));
		fifo_full = 1'b1;
		repeat (2) @(negedge clk_sys);
		count_conv(100);
		chk("paused", 16'd0, 16'(n));
		fifo_full = 1'b0;
		count_conv(20);
		chk("resumed", 16'd1, 16'(n));
		wr(OFF_BURST, 16'h0002, 1'b0);
		count_conv(40);
		chk("odd_cmd", 16'd2, 16'(n));
		wr(OFF_BURST, 16'h0000, 1'b0);
		count_conv(60);
		chk("stopped", 16'd0, {15'(n), mux_hold});
		cmd9(9'b101000101);
		dat16(16'hAA55);
		pw(8'h00);
		chk("rom_locked", 16'h0000, mem_model.mem[5]);
		cmd9(9'b100110000);
		pw(8'h00);
		cmd9(9'b101000101);
		dat16(16'hAA55);
		pw(8'h00);
		chk("rom_prog", 16'hAA55, mem_model.mem[5]);
		cmd9(9'b110000101);
		repeat (4) @(negedge clk_sys);
		rd(OFF_ROM_PORT, 1'b0);
		chk("rom_bit", 16'h0080, rd_val & 16'h0080);
		pw(8'h00);
		cmd9(9'b100000000);
		pw(8'h00);
		cmd9(9'b101000101);
		dat16(16'h1234);
		pw(8'h00);
		chk("rom_off", 16'hAA55, mem_model.mem[5]);
		report_and_stop();
	end
endmodule : tb_daq_board_control_port_regs
